/* File: core/smc_pkg.sv */
// Constants and types for the sleep-mode clock controller
package smc_pkg;

  // Mode-select field width and encodings
  localparam int unsigned MODE_W = 3;
  localparam logic [2:0] MODE_IDLE    = 3'h0;
  localparam logic [2:0] MODE_ADC_NR  = 3'h1;
  localparam logic [2:0] MODE_PDOWN   = 3'h2;
  localparam logic [2:0] MODE_PSAVE   = 3'h3;
  localparam logic [2:0] MODE_STANDBY = 3'h6;
  localparam logic [2:0] MODE_EXT_SB  = 3'h7;
  localparam logic [2:0] MODE_DEEP    = 3'h4;

  // Number of software-selectable power-saving modes
  localparam int unsigned NUM_MODES = 6;

  // Clock-run vector bit positions
  localparam int unsigned CK_CPU   = 0;
  localparam int unsigned CK_SRAM  = 1;
  localparam int unsigned CK_TIMER = 2;
  localparam int unsigned CK_SPI   = 3;
  localparam int unsigned CK_IRQ   = 4;
  localparam int unsigned CK_ASYNC = 5;
  localparam int unsigned CK_ADC   = 6;
  localparam int unsigned CK_RCOSC = 7;
  localparam int unsigned CK_WDT   = 8;
  localparam int unsigned CK_SYMC  = 9;
  localparam int unsigned CK_LFOSC = 10;
  localparam int unsigned CK_W     = 11;

  // Full activity (also the reset value) and all-off value
  localparam logic [10:0] RUN_ALL  = 11'h7ff;
  localparam logic [10:0] RUN_NONE = 11'h000;

  // Controller states
  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP} smc_state_type;

endpackage

/* File: core/smc_ctrl.sv */
// Sleep-mode controller: mode decode, clock run enables and wake handling
// Overview of operation
// - Six selectable sleep modes, fixed clock sets
// - Idle halts CPU only, peripherals keep running
// - Power-down stops oscillator, retains registers
// - Power-save keeps asynchronous timer running
// - Noise reduction keeps only async timer, converter
// - Standby keeps RC oscillator running
// - Extended standby keeps RC oscillator, async timer
// - Deep sleep powers off non-retaining blocks
// - Deep sleep: watchdog, symbol counter, LF oscillator optional
`timescale 1ns/1ps
`default_nettype none

module smc_ctrl (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Software control, same clock domain
  input  wire logic [2:0]  mode_sel,
  input  wire logic        sleep_req,
  input  wire logic        sleep_enable,
  input  wire logic        deep_keep_wdt,
  input  wire logic        deep_keep_symc,
  input  wire logic        deep_keep_lfosc,
  // Wake sources from pins or other clocks
  input  wire logic        wake_irq,
  // Clock run enables and power state
  output logic [10:0]      clk_run,
  output logic             domain_power,
  output logic             retain_ok,
  output logic             sleeping,
  output logic             resume
);

  // Returns the run set for a mode; invalid codes keep everything on
  function automatic logic [10:0] run_set(input logic [2:0] m, input logic kw,
                                          input logic ks, input logic kl);
    logic [10:0] r;
    r = smc_pkg::RUN_NONE;
    unique case (m)
      smc_pkg::MODE_IDLE:
      begin
        r = smc_pkg::RUN_ALL;
        r[smc_pkg::CK_CPU] = 1'b0;
      end
      smc_pkg::MODE_ADC_NR:
      begin
        r[smc_pkg::CK_ASYNC] = 1'b1;
        r[smc_pkg::CK_ADC] = 1'b1;
      end
      smc_pkg::MODE_PDOWN:
        r = smc_pkg::RUN_NONE;
      smc_pkg::MODE_PSAVE:
        r[smc_pkg::CK_ASYNC] = 1'b1;
      smc_pkg::MODE_STANDBY:
        r[smc_pkg::CK_RCOSC] = 1'b1;
      smc_pkg::MODE_EXT_SB:
      begin
        r[smc_pkg::CK_RCOSC] = 1'b1;
        r[smc_pkg::CK_ASYNC] = 1'b1;
      end
      smc_pkg::MODE_DEEP:
      begin
        r[smc_pkg::CK_WDT] = kw;
        r[smc_pkg::CK_SYMC] = ks;
        r[smc_pkg::CK_LFOSC] = kl;
      end
      default:
        r = smc_pkg::RUN_ALL;
    endcase
    return r;
  endfunction

  // True for the six sleep modes plus deep sleep; code 5 is refused
  function automatic logic mode_valid(input logic [2:0] m);
    return (m == smc_pkg::MODE_IDLE) || (m == smc_pkg::MODE_ADC_NR) ||
           (m == smc_pkg::MODE_PDOWN) || (m == smc_pkg::MODE_PSAVE) ||
           (m == smc_pkg::MODE_STANDBY) || (m == smc_pkg::MODE_EXT_SB) ||
           (m == smc_pkg::MODE_DEEP);
  endfunction

  // Wake input synchroniser: first stage read only by second
  logic wake_s1;
  logic wake_s2;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
    end
    else
    begin
      wake_s1 <= wake_irq;
      wake_s2 <= wake_s1;
    end
  end

  smc_pkg::smc_state_type state;
  smc_pkg::smc_state_type next_state;
  logic [2:0]  mode;
  logic [2:0]  next_mode;
  logic [10:0] next_clk_run;
  logic        next_domain_power;
  logic        next_resume;

  // Next-state logic: mode latched only at sleep entry
  always_comb
  begin
    next_state = state;
    next_mode = mode;
    next_resume = 1'b0;
    unique case (state)
      smc_pkg::ST_ACTIVE:
      begin
        // Ignore invalid codes so a bad write cannot stall the CPU
        if (sleep_req && sleep_enable && mode_valid(mode_sel))
        begin
          next_state = smc_pkg::ST_SLEEP;
          next_mode = mode_sel;
        end
      end
      smc_pkg::ST_SLEEP:
      begin
        if (wake_s2)
        begin
          next_state = smc_pkg::ST_ACTIVE;
          next_resume = 1'b1;
        end
      end
    endcase
    if (next_state == smc_pkg::ST_SLEEP)
      next_clk_run = run_set(next_mode, deep_keep_wdt, deep_keep_symc,
                             deep_keep_lfosc);
    else
      next_clk_run = smc_pkg::RUN_ALL;
    // Only deep sleep removes power from non-retaining domains
    next_domain_power = !((next_state == smc_pkg::ST_SLEEP) &&
                          (next_mode == smc_pkg::MODE_DEEP));
  end

  // State registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= smc_pkg::ST_ACTIVE;
      mode <= smc_pkg::MODE_IDLE;
      clk_run <= smc_pkg::RUN_ALL;
      domain_power <= 1'b1;
      resume <= 1'b0;
    end
    else
    begin
      state <= next_state;
      mode <= next_mode;
      clk_run <= next_clk_run;
      domain_power <= next_domain_power;
      resume <= next_resume;
    end
  end

  // Retention is guaranteed whenever domains stay powered
  assign retain_ok = domain_power;
  assign sleeping = (state == smc_pkg::ST_SLEEP);

  // Checks
  idle_cpu_off_a: assert property (@(posedge clk) disable iff (!resetn)
    (sleeping && mode == smc_pkg::MODE_IDLE) |->
      (!clk_run[smc_pkg::CK_CPU] && clk_run[smc_pkg::CK_SPI] && clk_run[smc_pkg::CK_IRQ]))
    else $error("idle clock set wrong");
  pdown_all_off_a: assert property (@(posedge clk) disable iff (!resetn)
    (sleeping && mode == smc_pkg::MODE_PDOWN) |-> clk_run == smc_pkg::RUN_NONE)
    else $error("power-down left a clock running");
  psave_async_a: assert property (@(posedge clk) disable iff (!resetn)
    (sleeping && mode == smc_pkg::MODE_PSAVE) |->
      (clk_run[smc_pkg::CK_ASYNC] && !clk_run[smc_pkg::CK_CPU]))
    else $error("power-save async timer stopped");
  adc_nr_set_a: assert property (@(posedge clk) disable iff (!resetn)
    (sleeping && mode == smc_pkg::MODE_ADC_NR) |->
      (clk_run[smc_pkg::CK_ADC] && !clk_run[smc_pkg::CK_TIMER]))
    else $error("noise reduction clock set wrong");
  stby_rcosc_a: assert property (@(posedge clk) disable iff (!resetn)
    (sleeping && mode == smc_pkg::MODE_STANDBY) |->
      (clk_run[smc_pkg::CK_RCOSC] && !clk_run[smc_pkg::CK_ASYNC]))
    else $error("standby clock set wrong");
  ext_stby_a: assert property (@(posedge clk) disable iff (!resetn)
    (sleeping && mode == smc_pkg::MODE_EXT_SB) |->
      (clk_run[smc_pkg::CK_RCOSC] && clk_run[smc_pkg::CK_ASYNC]))
    else $error("extended standby clock set wrong");
  deep_power_a: assert property (@(posedge clk) disable iff (!resetn)
    (sleeping && mode == smc_pkg::MODE_DEEP) |-> !domain_power)
    else $error("deep sleep left domains powered");
  deep_keep_a: assert property (@(posedge clk) disable iff (!resetn)
    (sleeping && mode == smc_pkg::MODE_DEEP) |->
      (clk_run[smc_pkg::CK_WDT] == $past(deep_keep_wdt)))
    else $error("deep sleep watchdog option ignored");
  wake_resume_a: assert property (@(posedge clk) disable iff (!resetn)
    (sleeping && wake_s2) |=> (!sleeping && resume && clk_run == smc_pkg::RUN_ALL))
    else $error("wake did not restore clocks");
  enter_sleep_a: assert property (@(posedge clk) disable iff (!resetn)
    (!sleeping && sleep_req && sleep_enable && mode_sel == smc_pkg::MODE_PSAVE)
      |=> (sleeping && mode == smc_pkg::MODE_PSAVE))
    else $error("sleep request not taken");
  enter_any_a: assert property (@(posedge clk) disable iff (!resetn)
    (!sleeping && sleep_req && sleep_enable && mode_valid(mode_sel))
      |=> (sleeping && mode == $past(mode_sel)))
    else $error("valid sleep request not taken");
  // A refused code must not gate anything, or the CPU would stall
  bad_code_a: assert property (@(posedge clk) disable iff (!resetn)
    (!sleeping && sleep_req && !mode_valid(mode_sel)) |=> !sleeping)
    else $error("invalid mode code entered sleep");
  asleep_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    (sleeping && !wake_s2) |=> (sleeping && $stable(mode) && $stable(domain_power)))
    else $error("sleep state left without wake");
  active_run_a: assert property (@(posedge clk) disable iff (!resetn)
    !sleeping |-> (clk_run == smc_pkg::RUN_ALL && domain_power))
    else $error("active state with clocks gated");
  resume_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    resume |=> !resume)
    else $error("resume held longer than one cycle");
  // Deep sleep keeps only the three optional clocks, each as asked
  deep_opt_a: assert property (@(posedge clk) disable iff (!resetn)
    (sleeping && mode == smc_pkg::MODE_DEEP) |->
      (clk_run[smc_pkg::CK_SYMC] == $past(deep_keep_symc) &&
       clk_run[smc_pkg::CK_LFOSC] == $past(deep_keep_lfosc) &&
       clk_run[smc_pkg::CK_RCOSC:smc_pkg::CK_CPU] == 8'h00))
    else $error("deep sleep optional clock set wrong");

endmodule

`default_nettype wire

/* File: test/test_smc_ctrl.sv */
// Self-checking bench for the sleep-mode clock controller
`timescale 1ns/1ps
`default_nettype none
module test_smc_ctrl;
  logic        clk;
  logic        resetn;
  logic [2:0]  mode_sel;
  logic        sleep_req;
  logic        sleep_enable;
  logic [2:0]  keep;
  logic        wake_irq;
  logic [10:0] clk_run;
  logic        domain_power;
  logic        retain_ok;
  logic        sleeping;
  logic        resume;
  int          n_mismatch;
  int          checks_done;

  smc_ctrl u_dut (.clk(clk), .resetn(resetn), .mode_sel(mode_sel), .sleep_req(sleep_req),
    .sleep_enable(sleep_enable), .deep_keep_wdt(keep[0]), .deep_keep_symc(keep[1]),
    .deep_keep_lfosc(keep[2]), .wake_irq(wake_irq), .clk_run(clk_run),
    .domain_power(domain_power), .retain_ok(retain_ok), .sleeping(sleeping), .resume(resume));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Value compare, counted
  task automatic cmp(input string what, input logic [10:0] exp, input logic [10:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Single-bit flag compare, counted; unknowns fail
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One-cycle sleep request; outputs judged one edge later
  task automatic go_sleep(input logic [2:0] m, input logic en);
    @(negedge clk);
    mode_sel     = m;
    sleep_enable = en;
    sleep_req    = 1'b1;
    @(negedge clk);
    sleep_req    = 1'b0;
  endtask

  // Wake through the synchroniser, bounded wait, then resume pulse
  task automatic wake_up;
    int n;
    n = 0;
    @(negedge clk);
    wake_irq = 1'b1;
    while (sleeping !== 1'b0 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    wake_irq = 1'b0;
    if (n == 8)
    begin
      // A hang ends the run through the one closing report
      n_mismatch++;
      stop_test();
    end
    else
    begin
      cmp("wake edges", 11'h003, 11'(n));
      cmp_bit("resume", 1'b1, resume);
      cmp("run after wake", 11'h7ff, clk_run);
      @(negedge clk);
      cmp_bit("resume drop", 1'b0, resume);
    end
  endtask

  // Reset release: full activity at release and the two edges after
  task automatic sc_reset;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    cmp("reset run", 11'h7ff, clk_run);
    cmp_bit("reset asleep", 1'b0, sleeping);
    repeat (2)
    begin
      @(negedge clk);
      cmp("run after release", 11'h7ff, clk_run);
      cmp_bit("resume after release", 1'b0, resume);
    end
  endtask

  // One non-deep mode; mask keeps only the clocks the mode fixes
  task automatic one_mode(input logic [2:0] m, input logic [10:0] exp, input logic [10:0] mask);
    go_sleep(m, 1'b1);
    cmp_bit("asleep", 1'b1, sleeping);
    cmp("mode run set", exp, clk_run & mask);
    cmp("retain", 11'h003, 11'({domain_power, retain_ok}));
    wake_up();
  endtask

  // Every non-deep mode, with retention kept
  task automatic sc_modes;
    one_mode(3'h0, 11'h01e, 11'h01f);
    one_mode(3'h1, 11'h060, 11'h7ff);
    one_mode(3'h2, 11'h000, 11'h7ff);
    one_mode(3'h3, 11'h020, 11'h7ff);
    one_mode(3'h6, 11'h080, 11'h7ff);
    one_mode(3'h7, 11'h0a0, 11'h7ff);
  endtask

  // Refused requests: enable low, invalid code
  task automatic sc_refused;
    go_sleep(3'h2, 1'b0);
    cmp_bit("no enable", 1'b0, sleeping);
    go_sleep(3'h5, 1'b1);
    cmp_bit("bad code", 1'b0, sleeping);
    cmp("bad code run", 11'h7ff, clk_run);
  endtask

  // Power-save, then a new request while asleep is ignored
  task automatic sc_ignore;
    go_sleep(3'h3, 1'b1);
    go_sleep(3'h2, 1'b1);
    cmp("asleep ignore", 11'h020, clk_run);
    cmp_bit("still asleep", 1'b1, sleeping);
    wake_up();
  endtask

  // Deep sleep, keep bits followed live
  task automatic sc_deep;
    keep = 3'h5;
    go_sleep(3'h4, 1'b1);
    cmp("deep run", 11'h500, clk_run);
    cmp("deep power", 11'h000, 11'({domain_power, retain_ok}));
    keep = 3'h2;
    @(negedge clk);
    cmp("deep live", 11'h200, clk_run);
    wake_up();
    cmp("power back", 11'h003, 11'({domain_power, retain_ok}));
    keep = 3'h0;
  endtask

  // Reset in mid-sleep returns to full activity at once, then sleeps again
  task automatic sc_reset_asleep;
    go_sleep(3'h2, 1'b1);
    resetn = 1'b0;
    #1;
    cmp("reset asleep run", 11'h7ff, clk_run);
    cmp_bit("reset mid sleep", 1'b0, sleeping);
    @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    cmp("run after second release", 11'h7ff, clk_run);
    go_sleep(3'h3, 1'b1);
    cmp("sleep after release", 11'h020, clk_run);
    wake_up();
  endtask

  initial
  begin
    n_mismatch = 0;
    checks_done = 0;
    resetn = 1'b0;
    mode_sel = 3'h0;
    sleep_req = 1'b0;
    sleep_enable = 1'b0;
    keep = 3'h0;
    wake_irq = 1'b0;
    sc_reset();
    sc_modes();
    sc_refused();
    sc_ignore();
    sc_deep();
    sc_reset_asleep();
    stop_test();
  end
endmodule
`default_nettype wire
